//--- verilog/dfll_pkg.sv
// constants, field layouts and carrier types for the oscillator trim loop
// assumes one system clock; register bus is classic wishbone, 32-bit data
package dfll_pkg;
	localparam int FINE_W = 7;
	localparam int COARSE_W = 6;
	localparam int CAL_W = FINE_W + COARSE_W;
	localparam int COMP_W = 20;
	localparam int IDX_W = 6;
	localparam int IDX_LSB = 2;
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	localparam int EN_BIT = 0;
	localparam int REFSEL_BIT = 0;
	localparam int BYTE_W = 8;
	localparam int HI_NIB_W = COMP_W - 2 * BYTE_W;
	localparam logic [IDX_W-1:0] IDX_CTRL = 6'h00;
	localparam logic [IDX_W-1:0] IDX_FINE = 6'h02;
	localparam logic [IDX_W-1:0] IDX_COARSE = 6'h03;
	localparam logic [IDX_W-1:0] IDX_CMP_LO = 6'h04;
	localparam logic [IDX_W-1:0] IDX_CMP_MID = 6'h05;
	localparam logic [IDX_W-1:0] IDX_CMP_HI = 6'h06;
	localparam logic [IDX_W-1:0] IDX_REFSEL = 6'h08;
	localparam logic [FINE_W-1:0] FINE_MID = 7'h40;
	localparam logic [FINE_W-1:0] FINE_MAX = 7'h7f;
	localparam logic [FINE_W-1:0] FINE_MIN = 7'h00;
	localparam logic [COARSE_W-1:0] COARSE_RST = 6'h00;
	localparam logic [COMP_W-1:0] COMP_NOMINAL = 20'h0_7a12;
	localparam int REF_SRC_HZ = 32768;
	localparam int REF_HZ = 1024;
	localparam int REF_DIV = REF_SRC_HZ / REF_HZ;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [WB_AW-1:0] adr;
		logic [3:0] sel;
		logic [WB_DW-1:0] dat;
	} wbReq_t;

	typedef enum logic [1:0] {LOOP_OFF, LOOP_ALIGN, LOOP_MEASURE} loopState_t;

	// implemented bits of each register; everything else reads zero
	function automatic logic [BYTE_W-1:0] regMask(input logic [IDX_W-1:0] idx);
		case (idx)
			IDX_CTRL: regMask = 8'h01;
			IDX_FINE: regMask = 8'h7f;
			IDX_COARSE: regMask = 8'h3f;
			IDX_CMP_LO: regMask = 8'hff;
			IDX_CMP_MID: regMask = 8'hff;
			IDX_CMP_HI: regMask = 8'h0f;
			IDX_REFSEL: regMask = 8'h01;
			default: regMask = 8'h00;
		endcase
	endfunction
endpackage

//--- verilog/ref_divider.sv
// divides the selected 32.768 kHz reference tick stream to a 1.024 kHz pulse
// ticks arrive as one-cycle pulses already synchronous to clk_sys
`timescale 1ns/1ps
module ref_divider #(
	parameter int DIV = dfll_pkg::REF_DIV
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic useXtal,
	input wire logic tickInt,
	input wire logic tickXtal,
	output logic refPulse_q
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	logic [CW-1:0] cnt_q;
	logic tick;

	assign tick = useXtal ? tickXtal : tickInt;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (tick) begin
			cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			refPulse_q <= 1'b0;
		end else begin
			refPulse_q <= tick && (cnt_q == LAST);
		end
	end
endmodule // ref_divider

//--- verilog/osc_period_counter.sv
// counts oscillator ticks between clears; saturates rather than wraps
// oscTick is a one-cycle pulse per oscillator cycle, synchronous to clk_sys
`timescale 1ns/1ps
module osc_period_counter #(
	parameter int W = dfll_pkg::COMP_W
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clear,
	input wire logic oscTick,
	output logic [W-1:0] count_q
);
	localparam logic [W-1:0] SAT = '1;

	// saturating keeps a stuck-fast oscillator reading as too fast
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_q <= '0;
		end else if (clear) begin
			count_q <= oscTick ? W'(1) : '0;
		end else if (oscTick && count_q != SAT) begin
			count_q <= count_q + 1'b1;
		end
	end
endmodule // osc_period_counter

//--- verilog/dfll_autocal.sv
// frequency-locked trim loop for one internal oscillator, with its registers
// assumes a classic wishbone master, ticks synchronous to clk_sys,
// and a factory coarse trim that is stable when reset is released
`timescale 1ns/1ps
module dfll_autocal #(
	parameter logic [dfll_pkg::COMP_W-1:0] COMP_DEFAULT = dfll_pkg::COMP_NOMINAL
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire dfll_pkg::wbReq_t wbReq,
	output logic [dfll_pkg::WB_DW-1:0] wbDatOut,
	output logic wbAck,
	input wire logic oscTick,
	input wire logic refIntTick,
	input wire logic refXtalTick,
	input wire logic [dfll_pkg::COARSE_W-1:0] factoryCoarse,
	output logic [dfll_pkg::CAL_W-1:0] calValue,
	output logic loopActive
);
	logic enable_q;
	logic refSel_q;
	logic [dfll_pkg::FINE_W-1:0] fine_q;
	logic [dfll_pkg::COARSE_W-1:0] coarse_q;
	logic [dfll_pkg::COMP_W-1:0] comp_q;
	logic loadPending_q;
	dfll_pkg::loopState_t state_q;
	dfll_pkg::loopState_t state_d;
	logic ack_q;
	logic [dfll_pkg::WB_DW-1:0] dat_q;
	logic [dfll_pkg::CAL_W-1:0] cal_q;
	logic active_q;
	logic refPulse;
	logic [dfll_pkg::COMP_W-1:0] oscCount;
	logic reqValid;
	logic wrStrobe;
	logic [dfll_pkg::IDX_W-1:0] idx;
	logic [dfll_pkg::BYTE_W-1:0] wrByte;
	logic [dfll_pkg::BYTE_W-1:0] rdRaw;
	logic swAllowed;
	logic stepUp;
	logic stepDn;

	assign wbDatOut = dat_q;
	assign wbAck = ack_q;
	assign calValue = cal_q;
	assign loopActive = active_q;

	// bus decode: one word per register, byte lane 0 carries the data
	assign idx = wbReq.adr[dfll_pkg::IDX_LSB +: dfll_pkg::IDX_W];
	assign reqValid = wbReq.cyc && wbReq.stb && !ack_q;
	assign wrStrobe = reqValid && wbReq.we && wbReq.sel[0];
	assign wrByte = wbReq.dat[dfll_pkg::BYTE_W-1:0] & dfll_pkg::regMask(idx);
	assign swAllowed = !enable_q;

	ref_divider #(
		.DIV(dfll_pkg::REF_DIV)
	) u_ref (
		.clk_sys(clk_sys),
		.rst(rst),
		.useXtal(refSel_q),
		.tickInt(refIntTick),
		.tickXtal(refXtalTick),
		.refPulse_q(refPulse)
	);

	osc_period_counter #(
		.W(dfll_pkg::COMP_W)
	) u_cnt (
		.clk_sys(clk_sys),
		.rst(rst),
		.clear(refPulse),
		.oscTick(oscTick),
		.count_q(oscCount)
	);

	// control and reference select
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			enable_q <= 1'b0;
		end else if (wrStrobe && idx == dfll_pkg::IDX_CTRL) begin
			enable_q <= wrByte[dfll_pkg::EN_BIT];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			refSel_q <= 1'b0;
		end else if (wrStrobe && idx == dfll_pkg::IDX_REFSEL) begin
			refSel_q <= wrByte[dfll_pkg::REFSEL_BIT];
		end
	end

	// loop sequencing: the first partial reference period is thrown away
	always_comb begin
		state_d = state_q;
		case (state_q)
			dfll_pkg::LOOP_OFF: begin
				if (enable_q) begin
					state_d = dfll_pkg::LOOP_ALIGN;
				end
			end
			dfll_pkg::LOOP_ALIGN: begin
				if (!enable_q) begin
					state_d = dfll_pkg::LOOP_OFF;
				end else if (refPulse) begin
					state_d = dfll_pkg::LOOP_MEASURE;
				end
			end
			dfll_pkg::LOOP_MEASURE: begin
				if (!enable_q) begin
					state_d = dfll_pkg::LOOP_OFF;
				end
			end
			default: begin
				state_d = dfll_pkg::LOOP_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= dfll_pkg::LOOP_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// a period count below target means the oscillator is slow
	assign stepUp = enable_q && state_q == dfll_pkg::LOOP_MEASURE && refPulse
		&& oscCount < comp_q && fine_q != dfll_pkg::FINE_MAX;
	assign stepDn = enable_q && state_q == dfll_pkg::LOOP_MEASURE && refPulse
		&& oscCount > comp_q && fine_q != dfll_pkg::FINE_MIN;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fine_q <= dfll_pkg::FINE_MID;
		end else if (stepUp) begin
			fine_q <= fine_q + 1'b1;
		end else if (stepDn) begin
			fine_q <= fine_q - 1'b1;
		end else if (wrStrobe && swAllowed && idx == dfll_pkg::IDX_FINE) begin
			fine_q <= wrByte[dfll_pkg::FINE_W-1:0];
		end
	end

	// factory trim is caught on the first edge after release, not in reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			loadPending_q <= 1'b1;
		end else begin
			loadPending_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			coarse_q <= dfll_pkg::COARSE_RST;
		end else if (loadPending_q) begin
			coarse_q <= factoryCoarse;
		end else if (wrStrobe && swAllowed && idx == dfll_pkg::IDX_COARSE) begin
			coarse_q <= wrByte[dfll_pkg::COARSE_W-1:0];
		end
	end

	// compare bytes are locked while the loop runs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			comp_q <= COMP_DEFAULT;
		end else if (wrStrobe && swAllowed) begin
			case (idx)
				dfll_pkg::IDX_CMP_LO: begin
					comp_q[0 +: dfll_pkg::BYTE_W] <= wrByte;
				end
				dfll_pkg::IDX_CMP_MID: begin
					comp_q[dfll_pkg::BYTE_W +: dfll_pkg::BYTE_W] <= wrByte;
				end
				dfll_pkg::IDX_CMP_HI: begin
					comp_q[2 * dfll_pkg::BYTE_W +: dfll_pkg::HI_NIB_W] <=
						wrByte[dfll_pkg::HI_NIB_W-1:0];
				end
				default: begin
					comp_q <= comp_q;
				end
			endcase
		end
	end

	// trim output follows the registers whether or not the loop runs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cal_q <= {dfll_pkg::COARSE_RST, dfll_pkg::FINE_MID};
		end else begin
			cal_q <= {coarse_q, fine_q};
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			active_q <= 1'b0;
		end else begin
			active_q <= state_q == dfll_pkg::LOOP_MEASURE;
		end
	end

	// read side; unmapped words answer with zero
	always_comb begin
		case (idx)
			dfll_pkg::IDX_CTRL: rdRaw = {7'h00, enable_q};
			dfll_pkg::IDX_FINE: rdRaw = {1'b0, fine_q};
			dfll_pkg::IDX_COARSE: rdRaw = {2'h0, coarse_q};
			dfll_pkg::IDX_CMP_LO: rdRaw = comp_q[0 +: dfll_pkg::BYTE_W];
			dfll_pkg::IDX_CMP_MID: rdRaw = comp_q[dfll_pkg::BYTE_W +: dfll_pkg::BYTE_W];
			dfll_pkg::IDX_CMP_HI: rdRaw = {4'h0, comp_q[2 * dfll_pkg::BYTE_W +: dfll_pkg::HI_NIB_W]};
			dfll_pkg::IDX_REFSEL: rdRaw = {7'h00, refSel_q};
			default: rdRaw = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= reqValid;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dat_q <= '0;
		end else if (reqValid && !wbReq.we) begin
			dat_q <= {24'h00_0000, rdRaw & dfll_pkg::regMask(idx)};
		end
	end

	property p_enable_starts;
		@(posedge clk_sys) disable iff (rst)
		$rose(enable_q) |-> ##1 state_q == dfll_pkg::LOOP_ALIGN;
	endproperty
	a_enable_starts: assert property (p_enable_starts)
		else $error("loop did not start after enable");

	property p_manual_fine;
		@(posedge clk_sys) disable iff (rst)
		(wrStrobe && !enable_q && idx == dfll_pkg::IDX_FINE)
			|=> fine_q == $past(wbReq.dat[dfll_pkg::FINE_W-1:0]);
	endproperty
	a_manual_fine: assert property (p_manual_fine)
		else $error("manual fine write lost");

	property p_trim_follows;
		@(posedge clk_sys) disable iff (rst)
		!$past(rst) |-> calValue == $past({coarse_q, fine_q});
	endproperty
	a_trim_follows: assert property (p_trim_follows)
		else $error("trim output does not follow registers");

	property p_fine_reset;
		@(posedge clk_sys) disable iff (rst)
		$past(rst) |-> fine_q == dfll_pkg::FINE_MID;
	endproperty
	a_fine_reset: assert property (p_fine_reset)
		else $error("fine field not at midpoint after reset");

	property p_loop_owns_fine;
		@(posedge clk_sys) disable iff (rst)
		(enable_q && !stepUp && !stepDn) |=> $stable(fine_q);
	endproperty
	a_loop_owns_fine: assert property (p_loop_owns_fine)
		else $error("fine changed by other than the loop");

	property p_coarse_kept;
		@(posedge clk_sys) disable iff (rst)
		(enable_q && !loadPending_q) |=> $stable(coarse_q);
	endproperty
	a_coarse_kept: assert property (p_coarse_kept)
		else $error("coarse changed while loop ran");

	property p_factory_load;
		@(posedge clk_sys) disable iff (rst)
		loadPending_q |=> coarse_q == $past(factoryCoarse) ##1 !loadPending_q;
	endproperty
	a_factory_load: assert property (p_factory_load)
		else $error("factory coarse value not loaded");

	property p_comp_reset;
		@(posedge clk_sys) disable iff (rst)
		$past(rst) |-> comp_q == COMP_DEFAULT;
	endproperty
	a_comp_reset: assert property (p_comp_reset)
		else $error("compare value not at default after reset");

	property p_comp_locked;
		@(posedge clk_sys) disable iff (rst)
		enable_q |=> $stable(comp_q);
	endproperty
	a_comp_locked: assert property (p_comp_locked)
		else $error("compare value changed while loop ran");

	property p_comp_hi_read;
		@(posedge clk_sys) disable iff (rst)
		(reqValid && !wbReq.we && idx == dfll_pkg::IDX_CMP_HI && !wrStrobe)
			|=> wbAck && wbDatOut[3:0] == comp_q[19:16];
	endproperty
	a_comp_hi_read: assert property (p_comp_hi_read)
		else $error("high compare nibble read wrong");

	property p_reserved_zero;
		@(posedge clk_sys) disable iff (rst)
		(reqValid && !wbReq.we && idx == dfll_pkg::IDX_CTRL)
			|=> wbAck && wbDatOut[31:1] == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved control bits not zero");

	property p_ref_select;
		@(posedge clk_sys) disable iff (rst)
		refSel_q && $stable(refSel_q) && !refXtalTick |=> !refPulse;
	endproperty
	a_ref_select: assert property (p_ref_select)
		else $error("reference pulse without crystal tick");

	property p_step_up;
		@(posedge clk_sys) disable iff (rst)
		stepUp |=> fine_q == $past(fine_q) + 7'h01;
	endproperty
	a_step_up: assert property (p_step_up)
		else $error("fine did not step up by one");

	property p_bus_ack;
		@(posedge clk_sys) disable iff (rst)
		reqValid |=> wbAck ##1 !wbAck;
	endproperty
	a_bus_ack: assert property (p_bus_ack)
		else $error("bus answer not one cycle");

	c_step_up: cover property (@(posedge clk_sys) disable iff (rst) stepUp);
	c_step_dn: cover property (@(posedge clk_sys) disable iff (rst) stepDn);
	c_manual: cover property (@(posedge clk_sys) disable iff (rst)
		wrStrobe && !enable_q && idx == dfll_pkg::IDX_FINE);
	c_locked: cover property (@(posedge clk_sys) disable iff (rst)
		state_q == dfll_pkg::LOOP_MEASURE && refPulse && oscCount == comp_q);
endmodule // dfll_autocal

//--- verif/osc_trim_model.sv
// behavioural oscillator and reference tick sources (internal every 2 clocks, crystal every 3) around the trim loop
// assumes calValue from the loop under test; all pulses are synchronous to clk_sys
`timescale 1ns/1ps
module osc_trim_model #(
	parameter int INT_DIV = 2,
	parameter int XTAL_DIV = 3
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [dfll_pkg::CAL_W-1:0] calValue,
	output logic oscTick,
	output logic refIntTick,
	output logic refXtalTick
);
	logic [6:0] phase_q;
	int intCnt_q;
	int xtalCnt_q;

	// rate grows with the fine trim: (fine+1)/128 ticks per clock; coarse is not modelled
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{oscTick, phase_q} <= '0;
		end else begin
			{oscTick, phase_q} <= {1'b0, phase_q} + {1'b0, calValue[6:0]} + 8'h01;
		end
	end

	// two unrelated reference rates so the select bit shows in the locked trim
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			intCnt_q <= 0;
			xtalCnt_q <= 0;
		end else begin
			intCnt_q <= (intCnt_q == INT_DIV - 1) ? 0 : intCnt_q + 1;
			xtalCnt_q <= (xtalCnt_q == XTAL_DIV - 1) ? 0 : xtalCnt_q + 1;
		end
	end
	assign refIntTick = (intCnt_q == 0) && !rst;
	assign refXtalTick = (xtalCnt_q == 0) && !rst;
endmodule // osc_trim_model

//--- verif/dfll_autocal_tb.sv
// self-checking bench for the oscillator trim loop and its register bank
// assumes the oscillator model above; reads are checked from a queue of notes
`timescale 1ns/1ps
module dfll_autocal_tb;
	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
	} rdNote_t;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	dfll_pkg::wbReq_t wbReq = '0;
	logic [dfll_pkg::WB_DW-1:0] wbDatOut;
	logic wbAck;
	logic oscTick;
	logic refIntTick;
	logic refXtalTick;
	logic [dfll_pkg::COARSE_W-1:0] factoryCoarse;
	logic [dfll_pkg::CAL_W-1:0] calValue;
	logic loopActive;
	logic [31:0] lfsr = 32'hcf8b_6fc2;
	int bad_count = 0;
	int compares = 0;
	rdNote_t notes[$];
	rdNote_t note;

	always #2.5 clk_sys = ~clk_sys;

	dfll_autocal u_dfll_autocal (.clk_sys(clk_sys), .rst(rst), .wbReq(wbReq),
		.wbDatOut(wbDatOut), .wbAck(wbAck), .oscTick(oscTick), .refIntTick(refIntTick),
		.refXtalTick(refXtalTick), .factoryCoarse(factoryCoarse), .calValue(calValue),
		.loopActive(loopActive));
	osc_trim_model u_osc_trim_model (.clk_sys(clk_sys), .rst(rst), .calValue(calValue),
		.oscTick(oscTick), .refIntTick(refIntTick), .refXtalTick(refXtalTick));

	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [12:0] got, input logic [12:0] lo, input logic [12:0] hi);
		compares++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: got %h, want %h..%h", $time, got, lo, hi);
		end
	endtask

	// one classic cycle; a silent slave is left to the watchdog, not a local limit
	task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] d);
		@(posedge clk_sys);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1,
			dat: {24'h00_0000, d}};
		do begin
			@(posedge clk_sys);
		end while (wbAck !== 1'b1);
		wbReq.cyc <= 1'b0;
		wbReq.stb <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] lo, input logic [7:0] hi);
		notes.push_back('{lo, hi});
		xfer(1'b0, idx, 8'h00);
	endtask

	// read data is judged at the acknowledging edge against the oldest note
	always @(posedge clk_sys) begin
		if (wbAck === 1'b1 && wbReq.we === 1'b0 && notes.size() > 0) begin
			note = notes.pop_front();
			check(wbDatOut[12:0], {5'h00, note.lo}, {5'h00, note.hi});
			if (wbDatOut[31:13] !== 19'h0_0000) check(13'h1fff, 13'h0000, 13'h0000);
		end
	end

	task automatic conclude();
		$display("compares %0d, bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk_sys);
		bad_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		conclude();
	end

	initial begin
		logic [5:0] ix [4];
		logic [7:0] mk [4];
		logic [7:0] b;
		logic [7:0] fineW;
		logic [7:0] coarseW;
		ix = '{dfll_pkg::IDX_FINE, dfll_pkg::IDX_COARSE, dfll_pkg::IDX_CMP_HI, dfll_pkg::IDX_REFSEL};
		mk = '{8'h7f, 8'h3f, 8'h0f, 8'h01};
		lfsr = nextRand(lfsr);
		@(posedge clk_sys);
		factoryCoarse <= lfsr[5:0];
		@(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check(calValue, {factoryCoarse, dfll_pkg::FINE_MID}, {factoryCoarse, dfll_pkg::FINE_MID});
		rd(dfll_pkg::IDX_COARSE, {2'b00, factoryCoarse}, {2'b00, factoryCoarse});
		rd(dfll_pkg::IDX_FINE, {1'b0, dfll_pkg::FINE_MID}, {1'b0, dfll_pkg::FINE_MID});
		for (int i = 0; i < 3; i++) begin
			b = 8'(dfll_pkg::COMP_NOMINAL >> (8 * i));
			rd(dfll_pkg::IDX_CMP_LO + 6'(i), b, b);
		end
		wr(dfll_pkg::IDX_CTRL, 8'h00);
		rd(dfll_pkg::IDX_CTRL, 8'h00, 8'h00);
		wr(6'h01, 8'hff);
		rd(6'h01, 8'h00, 8'h00);
		rd(6'h07, 8'h00, 8'h00);
		// random field values; software keeps reserved bits at zero
		for (int i = 0; i < 4; i++) begin
			lfsr = nextRand(lfsr);
			b = lfsr[7:0] & mk[i];
			if (i == 0) fineW = b & mk[0];
			if (i == 1) coarseW = b & mk[1];
			wr(ix[i], b);
			rd(ix[i], b & mk[i], b & mk[i]);
		end
		repeat (2) @(posedge clk_sys);
		check(calValue, {coarseW[5:0], fineW[6:0]}, {coarseW[5:0], fineW[6:0]});
		// small target so the loop locks within a few thousand cycles
		wr(dfll_pkg::IDX_REFSEL, 8'h00);
		wr(dfll_pkg::IDX_CMP_LO, 8'h28);
		wr(dfll_pkg::IDX_CMP_MID, 8'h00);
		wr(dfll_pkg::IDX_CMP_HI, 8'h00);
		wr(dfll_pkg::IDX_FINE, 8'h40);
		wr(dfll_pkg::IDX_COARSE, 8'h15);
		wr(dfll_pkg::IDX_CTRL, 8'h01);
		repeat (100) @(posedge clk_sys);
		check({12'h000, loopActive}, 13'h0001, 13'h0001);
		wr(dfll_pkg::IDX_CMP_LO, 8'h99);
		wr(dfll_pkg::IDX_COARSE, 8'h2a);
		repeat (3000) @(posedge clk_sys);
		rd(dfll_pkg::IDX_FINE, 8'd76, 8'd82);
		rd(dfll_pkg::IDX_COARSE, 8'h15, 8'h15);
		rd(dfll_pkg::IDX_CMP_LO, 8'h28, 8'h28);
		check({7'h00, calValue[12:7]}, 13'h0015, 13'h0015);
		wr(dfll_pkg::IDX_CTRL, 8'h00);
		repeat (3) @(posedge clk_sys);
		check({12'h000, loopActive}, 13'h0000, 13'h0000);
		wr(dfll_pkg::IDX_REFSEL, 8'h01);
		wr(dfll_pkg::IDX_CTRL, 8'h01);
		repeat (4000) @(posedge clk_sys);
		rd(dfll_pkg::IDX_FINE, 8'd49, 8'd56);
		wr(dfll_pkg::IDX_CTRL, 8'h00);
		wr(dfll_pkg::IDX_FINE, 8'h11);
		rd(dfll_pkg::IDX_FINE, 8'h11, 8'h11);
		repeat (2) @(posedge clk_sys);
		check(calValue, {6'h15, 7'h11}, {6'h15, 7'h11});
		conclude();
	end
endmodule // dfll_autocal_tb
